// File: common/scsb_map.svh
// Offsets, field positions, masks, reset values and timing counts of the status bytes
`ifndef SCSB_MAP_SVH
`define SCSB_MAP_SVH

// Configuration memory byte addresses and the I/O port address
`define SCSB_SEC_ADDR 16'h0013
`define SCSB_FDC_ADDR 16'h0026
`define SCSB_PORT_ADDR 16'h0C65

// Security status byte fields
`define SCSB_SEC_BLANK 3'h6
`define SCSB_SEC_ADMIN 3'h5
`define SCSB_SEC_BOOT_DIS 3'h3
`define SCSB_SEC_LOCK 3'h2
`define SCSB_SEC_OVRD 3'h1
`define SCSB_SEC_PWSET 3'h0

// Diskette controller config byte field
`define SCSB_FDC_EN 3'h0

// Peripheral port byte fields
`define SCSB_PORT_PAR_HI 3'h6
`define SCSB_PORT_PAR_LO 3'h5
`define SCSB_PORT_HDC 3'h4
`define SCSB_PORT_SER 3'h1
`define SCSB_PAR_OFF 2'h3

// Software write masks; reserved and firmware-owned bits are cleared here
`define SCSB_SEC_WMASK 8'h4E
`define SCSB_FDC_WMASK 8'h01
`define SCSB_PORT_WMASK 8'h72

// Reset values
`define SCSB_SEC_RST 8'h00
`define SCSB_FDC_RST 8'h00
`define SCSB_PORT_RST 8'h00

// Last count of the boot wait, which lasts one cycle more, for the synchronised stored bytes to settle
`define SCSB_BOOT_SETTLE 2'h3

`endif

// File: common/scsb_pkg.sv
// Types shared by the status byte design
package scsb_pkg;
    typedef logic [7:0] scsb_byte_t;
    typedef enum logic [1:0] {SCSB_BOOT_WAIT, SCSB_BOOT_APPLY, SCSB_BOOT_RUN} scsb_boot_t;
endpackage

// File: dv/test_security_config_status_bytes.sv
// Self-checking bench for the security and peripheral status bytes
`timescale 1ns/1ps
`include "scsb_map.svh"
module test_security_config_status_bytes;
    import scsb_pkg::*;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [15:0] io_addr = 16'h0000;
    logic io_cfg_sel = 1'b0;
    logic io_rd = 1'b0;
    logic io_wr = 1'b0;
    scsb_byte_t io_wdata = 8'h00;
    scsb_byte_t io_rdata;
    logic io_rvalid;
    scsb_byte_t nv_sec_byte = 8'hB1;
    scsb_byte_t nv_fdc_byte = 8'hA4;
    logic pw_present = 1'b0;
    logic admin_pw_present = 1'b1;
    logic cfg_ready, screen_blank_en, kbd_lock_en, lock_override_en, diskette_boot_dis;
    logic password_set, admin_pw_set, fdc_en, par_en, hdc_en, serial_en;
    logic [1:0] par_map;
    int err_total = 0;
    int cmp_count = 0;
    int cyc = 0;
    int k;
    scsb_byte_t w;
    scsb_byte_t exp_b;

    scsb_top i_scsb_top (.ref_clk(ref_clk), .rst_n(rst_n), .io_addr(io_addr), .io_cfg_sel(io_cfg_sel),
        .io_rd(io_rd), .io_wr(io_wr), .io_wdata(io_wdata), .io_rdata(io_rdata), .io_rvalid(io_rvalid),
        .nv_sec_byte(nv_sec_byte), .nv_fdc_byte(nv_fdc_byte), .pw_present(pw_present),
        .admin_pw_present(admin_pw_present), .cfg_ready(cfg_ready), .screen_blank_en(screen_blank_en),
        .kbd_lock_en(kbd_lock_en), .lock_override_en(lock_override_en), .diskette_boot_dis(diskette_boot_dis),
        .password_set(password_set), .admin_pw_set(admin_pw_set), .fdc_en(fdc_en), .par_map(par_map),
        .par_en(par_en), .hdc_en(hdc_en), .serial_en(serial_en));

    // Free-running 100 MHz clock
    always #5 ref_clk = ~ref_clk;

    // Hang guard, far above the expected run length
    always @(posedge ref_clk)
    begin
        cyc = cyc + 1;
        if (cyc == 3000)
        begin
            err_total = err_total + 1;
            report_and_stop();
        end
    end

    // Compare and count
    task automatic check(input scsb_byte_t seen, input scsb_byte_t e);
        cmp_count = cmp_count + 1;
        if (seen !== e)
        begin
            err_total = err_total + 1;
            $display("unexpected at %0t: saw %h, expected %h", $time, seen, e);
        end
    endtask

    // One idle edge, then one write strobe
    task automatic wr(input logic sel, input logic [15:0] a, input scsb_byte_t d);
        @(negedge ref_clk);
        io_cfg_sel = sel;
        io_addr = a;
        io_wdata = d;
        io_wr = 1'b1;
        @(negedge ref_clk);
        io_wr = 1'b0;
    endtask

    // One read strobe, answer checked in its single valid cycle
    task automatic rd_chk(input logic sel, input logic [15:0] a, input scsb_byte_t e);
        @(negedge ref_clk);
        io_cfg_sel = sel;
        io_addr = a;
        io_rd = 1'b1;
        @(negedge ref_clk);
        io_rd = 1'b0;
        check({7'h00, io_rvalid}, 8'h01);
        check(io_rdata, e);
    endtask

    // Reset pulse and release on a falling edge
    task automatic do_reset();
        rst_n = 1'b0;
        repeat (8) @(negedge ref_clk);
        rst_n = 1'b1;
    endtask

    // Bounded wait for the boot load to finish
    task automatic wait_ready();
        k = 0;
        while (cfg_ready !== 1'b1 && k < 20)
        begin
            @(negedge ref_clk);
            k = k + 1;
        end
    endtask

    // Security flag outputs against an expected byte
    task automatic chk_sec(input scsb_byte_t e);
        check({4'h0, screen_blank_en, kbd_lock_en, lock_override_en, diskette_boot_dis},
            {4'h0, e[6], e[6] | e[2], e[1], e[3]});
    endtask

    // Counts, verdict and end of run
    task automatic report_and_stop();
        $display("comparisons %0d, mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    initial
    begin
        do_reset();
        // Accesses during boot: write dropped, read answers zero
        wr(1'b0, `SCSB_PORT_ADDR, 8'hFF);
        rd_chk(1'b1, `SCSB_SEC_ADDR, 8'h00);
        check({7'h00, cfg_ready}, 8'h00);
        wait_ready();
        check(k[7:0], 8'h01);
        // Boot values: stored bits kept, bits 5 and 0 from the straps
        rd_chk(1'b1, `SCSB_SEC_ADDR, 8'hB0);
        rd_chk(1'b1, `SCSB_FDC_ADDR, 8'hA4);
        rd_chk(1'b0, `SCSB_PORT_ADDR, 8'h00);
        check({6'h00, admin_pw_set, password_set}, 8'h02);
        chk_sec(8'hB0);
        check({7'h00, fdc_en}, 8'h00);
        // Security writes: reserved and firmware bits hold
        for (int i = 0; i < 3; i++)
        begin
            w = (i == 0) ? 8'hFF : ((i == 1) ? 8'h04 : 8'h40);
            exp_b = 8'hB0 | (w & 8'h4E);
            wr(1'b1, `SCSB_SEC_ADDR, w);
            rd_chk(1'b1, `SCSB_SEC_ADDR, exp_b);
            chk_sec(exp_b);
        end
        // Diskette controller enable, upper bits kept
        for (int j = 0; j < 2; j++)
        begin
            w = (j == 0) ? 8'hFF : 8'h00;
            wr(1'b1, `SCSB_FDC_ADDR, w);
            rd_chk(1'b1, `SCSB_FDC_ADDR, 8'hA4 | (w & 8'h01));
            check({7'h00, fdc_en}, {7'h00, w[0]});
        end
        // Every parallel mapping code with the disk and serial enables
        for (int i = 0; i < 4; i++)
        begin
            wr(1'b0, `SCSB_PORT_ADDR, {1'b1, i[1:0], i[0], 2'b11, i[1], 1'b1});
            exp_b = {1'b0, i[1:0], i[0], 2'b00, i[1], 1'b0};
            rd_chk(1'b0, `SCSB_PORT_ADDR, exp_b);
            check({6'h00, par_map}, {6'h00, i[1:0]});
            check({5'h00, par_en, hdc_en, serial_en}, {5'h00, i[1:0] != 2'h3, i[0], i[1]});
        end
        // Wrong space or unknown address: no effect, reads zero
        wr(1'b1, `SCSB_PORT_ADDR, 8'h00);
        wr(1'b0, `SCSB_SEC_ADDR, 8'h00);
        rd_chk(1'b1, 16'h0029, 8'h00);
        rd_chk(1'b1, `SCSB_PORT_ADDR, 8'h00);
        rd_chk(1'b0, `SCSB_PORT_ADDR, 8'h72);
        rd_chk(1'b1, `SCSB_SEC_ADDR, 8'hF0);
        // Second reset in mid-run with both straps flipped: port byte cleared, boot repeats
        pw_present = 1'b1;
        admin_pw_present = 1'b0;
        do_reset();
        check({6'h00, cfg_ready, hdc_en}, 8'h00);
        wait_ready();
        check({7'h00, cfg_ready}, 8'h01);
        rd_chk(1'b0, `SCSB_PORT_ADDR, 8'h00);
        rd_chk(1'b1, `SCSB_SEC_ADDR, 8'h91);
        check({6'h00, admin_pw_set, password_set}, 8'h01);
        report_and_stop();
    end
endmodule // test_security_config_status_bytes

// File: logic/scsb_byte_reg.sv
// One status byte with boot load and masked software write
`timescale 1ns/1ps
module scsb_byte_reg #(
    parameter logic [7:0] RST_VAL = 8'h00,
    parameter logic [7:0] WMASK = 8'hFF
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic load_en,
    input wire scsb_pkg::scsb_byte_t load_val,
    input wire logic wr_en,
    input wire scsb_pkg::scsb_byte_t wr_val,
    output scsb_pkg::scsb_byte_t q
);
    import scsb_pkg::*;

    scsb_byte_t val_q;
    scsb_byte_t val_d;

    // Boot load takes the whole byte; software only touches masked bits
    always_comb
    begin
        val_d = val_q;
        if (load_en)
        begin
            val_d = load_val;
        end
        else if (wr_en)
        begin
            val_d = (wr_val & WMASK) | (val_q & ~WMASK);
        end
    end

    // Byte storage
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            val_q <= RST_VAL;
        end
        else
        begin
            val_q <= val_d;
        end
    end

    assign q = val_q;
endmodule // scsb_byte_reg

// File: logic/scsb_top.sv
// Security and peripheral configuration status bytes
//
// Behaviour
// - At boot the stored configuration bytes are read and applied before any access is served.
// - Software reads the security status through config memory and the peripheral byte through the I/O port with no unlock.
// - Config byte 13h holds the security flags and its bits 7 and 4 are never changed by writes.
// - Bit 6 enables blanking after standby and also turns the lock feature on.
// - Bit 5 shows an administrator password and bit 3 set disables diskette boot.
// - Bit 2 enables the keyboard lock and is 0 by default.
// - Bit 1 enables the network server lock override.
// - Bit 0 is set by power-up firmware and shows whether a password is set.
// - Byte 26h and I/O port 0C65h carry the interface and controller enables.
// - Byte 26h bit 0 enables the diskette controller and bits 7 to 1 are kept.
// - Port bits 6,5 select parallel mapping: 00 primary, 01 secondary, 10 tertiary, 11 off.
// - Port bit 4 enables the fixed disk, bit 1 the serial interface, bits 7,3,2,0 are kept.
`timescale 1ns/1ps
`include "scsb_map.svh"
module scsb_top (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic [15:0] io_addr,
    input wire logic io_cfg_sel,
    input wire logic io_rd,
    input wire logic io_wr,
    input wire scsb_pkg::scsb_byte_t io_wdata,
    output scsb_pkg::scsb_byte_t io_rdata,
    output logic io_rvalid,
    input wire scsb_pkg::scsb_byte_t nv_sec_byte,
    input wire scsb_pkg::scsb_byte_t nv_fdc_byte,
    input wire logic pw_present,
    input wire logic admin_pw_present,
    output logic cfg_ready,
    output logic screen_blank_en,
    output logic kbd_lock_en,
    output logic lock_override_en,
    output logic diskette_boot_dis,
    output logic password_set,
    output logic admin_pw_set,
    output logic fdc_en,
    output logic [1:0] par_map,
    output logic par_en,
    output logic hdc_en,
    output logic serial_en
);
    import scsb_pkg::*;

    // Address decode shared by read and write paths
    function automatic logic [1:0] scsb_decode(input logic cfg, input logic [15:0] a);
        logic [1:0] sel;
        sel = 2'h0;
        if (cfg && a == `SCSB_SEC_ADDR)
        begin
            sel = 2'h1;
        end
        else if (cfg && a == `SCSB_FDC_ADDR)
        begin
            sel = 2'h2;
        end
        else if (!cfg && a == `SCSB_PORT_ADDR)
        begin
            sel = 2'h3;
        end
        return sel;
    endfunction

    // Two-stage synchronisers for the stored bytes and password strap levels
    scsb_byte_t sec_s1_q, sec_s2_q, fdc_s1_q, fdc_s2_q;
    logic [1:0] pw_s1_q, pw_s2_q;

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            sec_s1_q <= 8'h00;
            sec_s2_q <= 8'h00;
            fdc_s1_q <= 8'h00;
            fdc_s2_q <= 8'h00;
            pw_s1_q <= 2'h0;
            pw_s2_q <= 2'h0;
        end
        else
        begin
            sec_s1_q <= nv_sec_byte;
            sec_s2_q <= sec_s1_q;
            fdc_s1_q <= nv_fdc_byte;
            fdc_s2_q <= fdc_s1_q;
            pw_s1_q <= {admin_pw_present, pw_present};
            pw_s2_q <= pw_s1_q;
        end
    end

    // Boot sequencer state
    scsb_boot_t st_q, st_d;
    logic [1:0] cnt_q, cnt_d;
    logic ready_q, ready_d;

    // Wait for the synchronisers, apply stored bytes, then serve accesses
    always_comb
    begin
        st_d = st_q;
        cnt_d = cnt_q;
        ready_d = ready_q;
        unique case (st_q)
            SCSB_BOOT_WAIT:
            begin
                cnt_d = cnt_q + 2'h1;
                if (cnt_q == `SCSB_BOOT_SETTLE)
                begin
                    st_d = SCSB_BOOT_APPLY;
                end
            end
            SCSB_BOOT_APPLY:
            begin
                st_d = SCSB_BOOT_RUN;
                ready_d = 1'b1;
            end
            SCSB_BOOT_RUN:
            begin
                st_d = SCSB_BOOT_RUN;
            end
        endcase
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            st_q <= SCSB_BOOT_WAIT;
            cnt_q <= 2'h0;
            ready_q <= 1'b0;
        end
        else
        begin
            st_q <= st_d;
            cnt_q <= cnt_d;
            ready_q <= ready_d;
        end
    end

    // Byte load and write strobes
    logic apply;
    logic [1:0] wsel, rsel;
    scsb_byte_t sec_val, fdc_val, port_val, sec_load;
    assign apply = (st_q == SCSB_BOOT_APPLY);
    assign wsel = scsb_decode(io_cfg_sel, io_addr);
    assign rsel = wsel;
    // Firmware fills the password bits from the straps at power up
    assign sec_load = {sec_s2_q[7:6], pw_s2_q[1], sec_s2_q[4:1], pw_s2_q[0]};

    // Security flags; bits 7,5,4,0 are outside the write mask
    scsb_byte_reg #(.RST_VAL(`SCSB_SEC_RST), .WMASK(`SCSB_SEC_WMASK)) u_sec (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .load_en(apply),
        .load_val(sec_load),
        .wr_en(ready_q && io_wr && wsel == 2'h1),
        .wr_val(io_wdata),
        .q(sec_val)
    );

    // Diskette controller byte; only bit 0 is writable
    scsb_byte_reg #(.RST_VAL(`SCSB_FDC_RST), .WMASK(`SCSB_FDC_WMASK)) u_fdc (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .load_en(apply),
        .load_val(fdc_s2_q),
        .wr_en(ready_q && io_wr && wsel == 2'h2),
        .wr_val(io_wdata),
        .q(fdc_val)
    );

    // Peripheral port byte; not battery backed, so no boot load
    scsb_byte_reg #(.RST_VAL(`SCSB_PORT_RST), .WMASK(`SCSB_PORT_WMASK)) u_port (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .load_en(1'b0),
        .load_val(8'h00),
        .wr_en(ready_q && io_wr && wsel == 2'h3),
        .wr_val(io_wdata),
        .q(port_val)
    );

    // Read path and decoded control outputs
    scsb_byte_t rdata_d;
    logic [11:0] ctl_q, ctl_d;
    logic rvalid_q;
    scsb_byte_t rdata_q;

    always_comb
    begin
        rdata_d = 8'h00;
        if (ready_q)
        begin
            unique case (rsel)
                2'h1: rdata_d = sec_val;
                2'h2: rdata_d = fdc_val;
                2'h3: rdata_d = port_val;
                2'h0: rdata_d = 8'h00;
            endcase
        end
        ctl_d[0] = sec_val[`SCSB_SEC_BLANK];
        ctl_d[1] = sec_val[`SCSB_SEC_LOCK] | sec_val[`SCSB_SEC_BLANK];
        ctl_d[2] = sec_val[`SCSB_SEC_OVRD];
        ctl_d[3] = sec_val[`SCSB_SEC_BOOT_DIS];
        ctl_d[4] = sec_val[`SCSB_SEC_PWSET];
        ctl_d[5] = sec_val[`SCSB_SEC_ADMIN];
        ctl_d[6] = fdc_val[`SCSB_FDC_EN];
        ctl_d[8:7] = port_val[`SCSB_PORT_PAR_HI:`SCSB_PORT_PAR_LO];
        ctl_d[9] = port_val[`SCSB_PORT_HDC];
        ctl_d[10] = port_val[`SCSB_PORT_SER];
        ctl_d[11] = (port_val[`SCSB_PORT_PAR_HI:`SCSB_PORT_PAR_LO] != `SCSB_PAR_OFF);
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            rdata_q <= 8'h00;
            rvalid_q <= 1'b0;
            ctl_q <= 12'h000;
        end
        else
        begin
            rdata_q <= rdata_d;
            rvalid_q <= io_rd;
            ctl_q <= ctl_d;
        end
    end

    // Output assignments straight from flops
    assign io_rdata = rdata_q;
    assign io_rvalid = rvalid_q;
    assign cfg_ready = ready_q;
    assign screen_blank_en = ctl_q[0];
    assign kbd_lock_en = ctl_q[1];
    assign lock_override_en = ctl_q[2];
    assign diskette_boot_dis = ctl_q[3];
    assign password_set = ctl_q[4];
    assign admin_pw_set = ctl_q[5];
    assign fdc_en = ctl_q[6];
    assign par_map = ctl_q[8:7];
    assign par_en = ctl_q[11];
    assign hdc_en = ctl_q[9];
    assign serial_en = ctl_q[10];

    // Checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    sequence s_sec_wr;
        ready_q && io_wr && wsel == 2'h1;
    endsequence
    sequence s_boot_apply;
        st_q == SCSB_BOOT_WAIT && cnt_q == `SCSB_BOOT_SETTLE ##1 st_q == SCSB_BOOT_APPLY;
    endsequence

    boot_ready_a: assert property (s_boot_apply |=> ready_q && sec_val == $past(sec_load))
        else $error("stored bytes not applied at boot");
    boot_gate_a: assert property (!ready_q && io_wr |=> $stable(port_val))
        else $error("write taken before boot finished");
    read_sec_a: assert property (io_rd && ready_q && rsel == 2'h1 |=> io_rvalid && io_rdata == $past(sec_val))
        else $error("security byte read mismatch");
    sec_rsvd_a: assert property (s_sec_wr |=> sec_val[7] == $past(sec_val[7]) && sec_val[4] == $past(sec_val[4]))
        else $error("reserved security bit changed");
    blank_lock_a: assert property (screen_blank_en |-> kbd_lock_en)
        else $error("blanking without lock");
    sec_ro_a: assert property (s_sec_wr |=> sec_val[5] == $past(sec_val[5]) && sec_val[0] == $past(sec_val[0]))
        else $error("firmware-owned bit written");
    lock_default_a: assert property (st_q == SCSB_BOOT_WAIT |-> !sec_val[`SCSB_SEC_LOCK])
        else $error("lock not disabled by default");
    override_out_a: assert property (s_sec_wr ##1 1'b1 |=> lock_override_en == $past(io_wdata[1], 2))
        else $error("override output wrong");
    pw_boot_a: assert property (s_boot_apply |=> sec_val[0] == $past(pw_s2_q[0]))
        else $error("password state not loaded");
    fdc_write_a: assert property (ready_q && io_wr && wsel == 2'h2 |=> fdc_val == {$past(fdc_val[7:1]), $past(io_wdata[0])})
        else $error("diskette byte write wrong");
    port_rsvd_a: assert property (ready_q && io_wr && wsel == 2'h3 |=> (port_val & 8'h8D) == ($past(port_val) & 8'h8D))
        else $error("reserved port bit changed");
endmodule // scsb_top
